//--- global_config_and_gpio_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Doubler enable bit 2 powers the clock doubler up when 1, down when 0.
// - Crystal pin mode: 00 off, 01 crystal driver, 10 single-ended input, 11 unused.
// - Switch source bits 6:5 pick pin 0..3, used only with switch option on.
// - Bit 4 of the PLL block register powers the synthesizer/modulator block.
// - Bit 0 of the PLL block register enables the fractional PLL.
// - Input enable bits 2..0 enable receivers and dividers of inputs 3..1.
// - Output enable bits 2..0 enable drivers and logic of outputs 3..1.
// - Pin codes 0000 input, 0001 inverted input, 0010 drive low, 0011 high.
// - Codes 0100..0111 make status outputs: follow, invert, low-or-float, float-or-low.
// - Pin level status register shows every pin level regardless of mode.
// - Config registers hold odd pin in bits 7:4, even pin in bits 3:0.
// - Followed bit sits at address 0x40 plus register field, bit field picks position.
// - Status pick fields act only while the pin code is 01xx.
// - A pick naming an unimplemented status bit drives the pin low.
// - Pins may never follow the pin level status register itself.
module global_config_and_gpio_regs
  import gcfg_pkg::*;
#(
  parameter int          NUM_PINS    = 4,
  parameter logic [255:0] STATUS_IMPL = {256{1'b1}}
)
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // Register access port
  input  wire logic [11:0]         reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  // Status space followed by the pins, 8 bits per register from 0x40
  input  wire logic [255:0]        status_bits,
  input  wire logic                external_switch_option,
  // General-purpose pins
  input  wire logic [NUM_PINS-1:0] gpio_in,
  output logic      [NUM_PINS-1:0] gpio_out,
  output logic      [NUM_PINS-1:0] gpio_oe,
  output logic      [NUM_PINS-1:0] gpio_sense,
  // Block controls
  output logic                     doubler_enable,
  output logic      [1:0]          crystal_pin_mode,
  output logic                     crystal_driver_on,
  output logic                     osc_pin_a_single_ended,
  output logic                     external_switch,
  output logic                     synth_block_enable,
  output logic                     pll_enable,
  output logic      [2:0]          input_enable,
  output logic      [2:0]          output_enable
);
  import gcfg_pkg::*;

  // Pin fields and pick registers exist for four pins only
  if (NUM_PINS != 4)
  begin
    $error("global_config_and_gpio_regs serves exactly four pins");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
    masked = d & m;
  endfunction

  // Returns {implemented, value} of the picked status bit
  function automatic logic [1:0] pick_status(input logic [7:0] pick,
                                             input logic [255:0] bits,
                                             input logic [255:0] impl);
    logic [7:0] idx;
    idx = pick;
    // Refused as a source: a pin following its own level could hold itself
    if (pick[7:3] == PIN_LEVEL_STATUS_INDEX)
      pick_status = 2'b00;
    else
      pick_status = {impl[idx], bits[idx]};
  endfunction

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] master_config_first, next_master_config_first;
  logic [7:0] switch_source_select, next_switch_source_select;
  logic [7:0] pll_block_enable, next_pll_block_enable;
  logic [7:0] input_path_enable, next_input_path_enable;
  logic [7:0] output_path_enable, next_output_path_enable;
  logic [7:0] pin_config_low_pair, next_pin_config_low_pair;
  logic [7:0] pin_config_high_pair, next_pin_config_high_pair;
  logic [7:0] pin_pick [4];
  logic [7:0] next_pin_pick [4];
  logic [7:0] next_reg_rdata;
  logic [3:0] pin_level;

  always_comb
  begin
    next_master_config_first  = master_config_first;
    next_switch_source_select = switch_source_select;
    next_pll_block_enable     = pll_block_enable;
    next_input_path_enable    = input_path_enable;
    next_output_path_enable   = output_path_enable;
    next_pin_config_low_pair  = pin_config_low_pair;
    next_pin_config_high_pair = pin_config_high_pair;
    for (int i = 0; i < 4; i++)
      next_pin_pick[i] = pin_pick[i];
    if (reg_wr)
    begin
      // Reserved bits are masked off on the way in
      if (reg_addr == MASTER_CONFIG_FIRST_ADDR)
        next_master_config_first = masked(reg_wdata, MASTER_CONFIG_MASK);
      else if (reg_addr == SWITCH_SOURCE_SELECT_ADDR)
        next_switch_source_select = masked(reg_wdata, SWITCH_SOURCE_MASK);
      else if (reg_addr == PLL_BLOCK_ENABLE_ADDR)
        next_pll_block_enable = masked(reg_wdata, PLL_BLOCK_MASK);
      else if (reg_addr == INPUT_PATH_ENABLE_ADDR)
        next_input_path_enable = masked(reg_wdata, PATH_ENABLE_MASK);
      else if (reg_addr == OUTPUT_PATH_ENABLE_ADDR)
        next_output_path_enable = masked(reg_wdata, PATH_ENABLE_MASK);
      else if (reg_addr == PIN_CONFIG_LOW_PAIR_ADDR)
        next_pin_config_low_pair = reg_wdata;
      else if (reg_addr == PIN_CONFIG_HIGH_PAIR_ADDR)
        next_pin_config_high_pair = reg_wdata;
      else if (reg_addr == PIN0_STATUS_PICK_ADDR)
        next_pin_pick[0] = reg_wdata;
      else if (reg_addr == PIN1_STATUS_PICK_ADDR)
        next_pin_pick[1] = reg_wdata;
      else if (reg_addr == PIN2_STATUS_PICK_ADDR)
        next_pin_pick[2] = reg_wdata;
      else if (reg_addr == PIN3_STATUS_PICK_ADDR)
        next_pin_pick[3] = reg_wdata;
    end

    // Unmapped and write-only space reads zero
    next_reg_rdata = REG_RESET;
    if (reg_addr == MASTER_CONFIG_FIRST_ADDR)
      next_reg_rdata = master_config_first;
    else if (reg_addr == SWITCH_SOURCE_SELECT_ADDR)
      next_reg_rdata = switch_source_select;
    else if (reg_addr == PLL_BLOCK_ENABLE_ADDR)
      next_reg_rdata = pll_block_enable;
    else if (reg_addr == INPUT_PATH_ENABLE_ADDR)
      next_reg_rdata = input_path_enable;
    else if (reg_addr == OUTPUT_PATH_ENABLE_ADDR)
      next_reg_rdata = output_path_enable;
    else if (reg_addr == PIN_CONFIG_LOW_PAIR_ADDR)
      next_reg_rdata = pin_config_low_pair;
    else if (reg_addr == PIN_CONFIG_HIGH_PAIR_ADDR)
      next_reg_rdata = pin_config_high_pair;
    else if (reg_addr == PIN0_STATUS_PICK_ADDR)
      next_reg_rdata = pin_pick[0];
    else if (reg_addr == PIN1_STATUS_PICK_ADDR)
      next_reg_rdata = pin_pick[1];
    else if (reg_addr == PIN2_STATUS_PICK_ADDR)
      next_reg_rdata = pin_pick[2];
    else if (reg_addr == PIN3_STATUS_PICK_ADDR)
      next_reg_rdata = pin_pick[3];
    else if (reg_addr == PIN_LEVEL_STATUS_ADDR)
      next_reg_rdata = {4'h0, pin_level};
    // Idle cycles show zero, never a stale byte
    if (!reg_rd)
      next_reg_rdata = REG_RESET;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      master_config_first  <= REG_RESET;
      switch_source_select <= REG_RESET;
      pll_block_enable     <= REG_RESET;
      input_path_enable    <= REG_RESET;
      output_path_enable   <= REG_RESET;
      pin_config_low_pair  <= REG_RESET;
      pin_config_high_pair <= REG_RESET;
      for (int i = 0; i < 4; i++)
        pin_pick[i] <= REG_RESET;
      reg_rdata  <= REG_RESET;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      master_config_first  <= next_master_config_first;
      switch_source_select <= next_switch_source_select;
      pll_block_enable     <= next_pll_block_enable;
      input_path_enable    <= next_input_path_enable;
      output_path_enable   <= next_output_path_enable;
      pin_config_low_pair  <= next_pin_config_low_pair;
      pin_config_high_pair <= next_pin_config_high_pair;
      for (int i = 0; i < 4; i++)
        pin_pick[i] <= next_pin_pick[i];
      reg_rdata  <= next_reg_rdata;
      reg_rvalid <= reg_rd;
    end
  end

  // ---------------------------------------------------------------
  // Pins and block controls
  // ---------------------------------------------------------------
  // Controls are registered one cycle after the register update so that
  // every output comes straight from a flip-flop.
  logic [3:0] next_gpio_out, next_gpio_oe, next_gpio_sense;
  logic [1:0] next_xtal_mode;
  logic       next_doubler, next_xtal_drv, next_single_ended, next_ext_switch;
  logic       next_synth, next_pll;
  logic [2:0] next_in_en, next_out_en;

  always_comb
  begin
    logic [3:0] code;
    logic [1:0] st;
    logic [1:0] src;
    code = 4'h0;
    st   = 2'b00;
    src  = switch_source_select[SWITCH_SRC_LSB +: 2];
    for (int i = 0; i < 4; i++)
    begin
      code = (i < 2) ? pin_config_low_pair[4*i +: 4]
                     : pin_config_high_pair[4*(i-2) +: 4];
      st = pick_status(pin_pick[i], status_bits, STATUS_IMPL);
      next_gpio_out[i]   = 1'b0;
      next_gpio_oe[i]    = 1'b0;
      next_gpio_sense[i] = gpio_in[i] ^ (code == PIN_IN_INV);
      case (code)
        PIN_OUT_LOW:
          next_gpio_oe[i] = 1'b1;
        PIN_OUT_HIGH:
        begin
          next_gpio_oe[i]  = 1'b1;
          next_gpio_out[i] = 1'b1;
        end
        PIN_STAT, PIN_STAT_INV, PIN_STAT_LOW0, PIN_STAT_LOW1:
        begin
          next_gpio_oe[i] = 1'b1;
          if (!st[1])
            next_gpio_out[i] = 1'b0;
          else if (code == PIN_STAT)
            next_gpio_out[i] = st[0];
          else if (code == PIN_STAT_INV)
            next_gpio_out[i] = ~st[0];
          else if (code == PIN_STAT_LOW0)
            next_gpio_oe[i] = ~st[0];
          else
            next_gpio_oe[i] = st[0];
        end
        default:
          next_gpio_oe[i] = 1'b0;
      endcase
    end
    next_doubler      = master_config_first[DOUBLER_BIT];
    next_xtal_mode    = master_config_first[XTAL_MODE_LSB +: 2];
    next_xtal_drv     = (next_xtal_mode == XTAL_DRIVER);
    next_single_ended = (next_xtal_mode == XTAL_SINGLE_ENDED);
    // Uses the conditioned pin, so an inverted input switches on a low level
    next_ext_switch   = external_switch_option & gpio_sense[src];
    next_synth        = pll_block_enable[SYNTH_EN_BIT];
    next_pll          = pll_block_enable[PLL_EN_BIT];
    next_in_en        = input_path_enable[2:0];
    next_out_en       = output_path_enable[2:0];
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gpio_out               <= '0;
      gpio_oe                <= '0;
      gpio_sense             <= '0;
      pin_level              <= '0;
      doubler_enable         <= 1'b0;
      crystal_pin_mode       <= XTAL_OFF;
      crystal_driver_on      <= 1'b0;
      osc_pin_a_single_ended <= 1'b0;
      external_switch        <= 1'b0;
      synth_block_enable     <= 1'b0;
      pll_enable             <= 1'b0;
      input_enable           <= 3'h0;
      output_enable          <= 3'h0;
    end
    else
    begin
      gpio_out               <= next_gpio_out;
      gpio_oe                <= next_gpio_oe;
      gpio_sense             <= next_gpio_sense;
      pin_level              <= gpio_in;
      doubler_enable         <= next_doubler;
      crystal_pin_mode       <= next_xtal_mode;
      crystal_driver_on      <= next_xtal_drv;
      osc_pin_a_single_ended <= next_single_ended;
      external_switch        <= next_ext_switch;
      synth_block_enable     <= next_synth;
      pll_enable             <= next_pll;
      input_enable           <= next_in_en;
      output_enable          <= next_out_en;
    end
  end

endmodule

//--- gcfg_pkg.sv
package gcfg_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] MASTER_CONFIG_FIRST_ADDR  = 12'h009;
  localparam logic [11:0] SWITCH_SOURCE_SELECT_ADDR = 12'h00a;
  localparam logic [11:0] PLL_BLOCK_ENABLE_ADDR     = 12'h00b;
  localparam logic [11:0] INPUT_PATH_ENABLE_ADDR    = 12'h00c;
  localparam logic [11:0] OUTPUT_PATH_ENABLE_ADDR   = 12'h00d;
  localparam logic [11:0] PIN_CONFIG_LOW_PAIR_ADDR  = 12'h00e;
  localparam logic [11:0] PIN_CONFIG_HIGH_PAIR_ADDR = 12'h00f;
  localparam logic [11:0] PIN0_STATUS_PICK_ADDR     = 12'h012;
  localparam logic [11:0] PIN1_STATUS_PICK_ADDR     = 12'h013;
  localparam logic [11:0] PIN2_STATUS_PICK_ADDR     = 12'h014;
  localparam logic [11:0] PIN3_STATUS_PICK_ADDR     = 12'h015;
  localparam logic [11:0] STATUS_SPACE_BASE         = 12'h040;
  localparam logic [11:0] PIN_LEVEL_STATUS_ADDR     = 12'h042;
  localparam logic [4:0]  PIN_LEVEL_STATUS_INDEX    = 5'h02;

  // ---------------------------------------------------------------
  // Writable bit masks and reset value
  // ---------------------------------------------------------------
  localparam logic [7:0] MASTER_CONFIG_MASK  = 8'h07;
  localparam logic [7:0] SWITCH_SOURCE_MASK  = 8'h60;
  localparam logic [7:0] PLL_BLOCK_MASK      = 8'h11;
  localparam logic [7:0] PATH_ENABLE_MASK    = 8'h07;
  localparam logic [7:0] FULL_MASK           = 8'hff;
  localparam logic [7:0] REG_RESET           = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DOUBLER_BIT      = 2;
  localparam int XTAL_MODE_LSB    = 0;
  localparam int SWITCH_SRC_LSB   = 5;
  localparam int SYNTH_EN_BIT     = 4;
  localparam int PLL_EN_BIT       = 0;
  localparam int PICK_BIT_LSB     = 0;
  localparam int PICK_REG_LSB     = 3;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] XTAL_OFF          = 2'h0;
  localparam logic [1:0] XTAL_DRIVER       = 2'h1;
  localparam logic [1:0] XTAL_SINGLE_ENDED = 2'h2;

  localparam logic [3:0] PIN_IN            = 4'h0;
  localparam logic [3:0] PIN_IN_INV        = 4'h1;
  localparam logic [3:0] PIN_OUT_LOW       = 4'h2;
  localparam logic [3:0] PIN_OUT_HIGH      = 4'h3;
  localparam logic [3:0] PIN_STAT          = 4'h4;
  localparam logic [3:0] PIN_STAT_INV      = 4'h5;
  localparam logic [3:0] PIN_STAT_LOW0     = 4'h6;
  localparam logic [3:0] PIN_STAT_LOW1     = 4'h7;

  // Settling time software must wait before enabling the doubler
  localparam int XTAL_SETTLE_MS = 5;

endpackage

//--- gcfg_checker.sv
`timescale 1ns/1ps
module gcfg_checker
  import gcfg_pkg::*;
#(
  parameter int           NUM_PINS    = 4,
  parameter logic [255:0] STATUS_IMPL = {256{1'b1}}
)
(
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                rst_b,
  // Register port
  input wire logic [11:0]         reg_addr,
  input wire logic                reg_wr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic                reg_rvalid,
  // Pins and controls
  input wire logic                external_switch_option,
  input wire logic [NUM_PINS-1:0] gpio_in,
  input wire logic                external_switch,
  input wire logic                doubler_enable,
  input wire logic [1:0]          crystal_pin_mode,
  input wire logic                crystal_driver_on,
  input wire logic                osc_pin_a_single_ended,
  input wire logic                synth_block_enable,
  input wire logic                pll_enable,
  input wire logic [2:0]          input_enable,
  input wire logic [2:0]          output_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_read_valid: assert property (reg_rvalid == $past(reg_rd))
    else $error("read valid did not follow the read strobe");
  chk_idle_rdata: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_pll_write: assert property (reg_wr && reg_addr == PLL_BLOCK_ENABLE_ADDR |-> ##2
    (pll_enable == $past(reg_wdata[PLL_EN_BIT], 2)
    && synth_block_enable == $past(reg_wdata[SYNTH_EN_BIT], 2)))
    else $error("pll enables do not follow the write");
  chk_input_write: assert property (reg_wr && reg_addr == INPUT_PATH_ENABLE_ADDR |-> ##2
    input_enable == $past(reg_wdata[2:0], 2))
    else $error("input enables do not follow the write");
  chk_output_write: assert property (reg_wr && reg_addr == OUTPUT_PATH_ENABLE_ADDR |-> ##2
    output_enable == $past(reg_wdata[2:0], 2))
    else $error("output enables do not follow the write");
  chk_doubler_write: assert property (reg_wr && reg_addr == MASTER_CONFIG_FIRST_ADDR |-> ##2
    (doubler_enable == $past(reg_wdata[DOUBLER_BIT], 2)
    && crystal_pin_mode == $past(reg_wdata[1:0], 2)))
    else $error("doubler or crystal mode does not follow the write");
  chk_crystal_decode: assert property (crystal_driver_on == (crystal_pin_mode == XTAL_DRIVER)
    && osc_pin_a_single_ended == (crystal_pin_mode == XTAL_SINGLE_ENDED))
    else $error("crystal mode decode wrong");
  chk_level_read: assert property (reg_rd && reg_addr == PIN_LEVEL_STATUS_ADDR
    && $stable(gpio_in) |=> reg_rdata == 8'($past(gpio_in)))
    else $error("pin level read differs from the pins");
  chk_switch_gate: assert property (!$past(external_switch_option) |-> !external_switch)
    else $error("external switch active while option off");
endmodule

bind global_config_and_gpio_regs gcfg_checker #(.NUM_PINS(NUM_PINS), .STATUS_IMPL(STATUS_IMPL))
  chk_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .external_switch_option(external_switch_option), .gpio_in(gpio_in),
  .external_switch(external_switch), .doubler_enable(doubler_enable),
  .crystal_pin_mode(crystal_pin_mode), .crystal_driver_on(crystal_driver_on),
  .osc_pin_a_single_ended(osc_pin_a_single_ended), .synth_block_enable(synth_block_enable),
  .pll_enable(pll_enable), .input_enable(input_enable), .output_enable(output_enable));

//--- test_global_config_and_gpio_regs.sv
`timescale 1ns/1ps
module test_global_config_and_gpio_regs;
  import gcfg_pkg::*;
  // One status bit left unimplemented so that the drive-low case is reachable
  localparam logic [255:0] TB_IMPL = ~(256'h1 << 29);
  localparam logic [11:0] ADDRS [12] = '{12'h009, 12'h00a, 12'h00b, 12'h00c, 12'h00d,
    12'h00e, 12'h00f, 12'h012, 12'h013, 12'h014, 12'h015, 12'h030};
  localparam logic [7:0] MASKS [12] = '{8'h07, 8'h60, 8'h11, 8'h07, 8'h07, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
  logic         core_clk = 1'b0;
  logic         rst_b, reg_wr, reg_rd, external_switch_option;
  logic [11:0]  reg_addr;
  logic [7:0]   reg_wdata, reg_rdata, b, c, o;
  logic         reg_rvalid, external_switch, doubler_enable, crystal_driver_on;
  logic         osc_pin_a_single_ended, synth_block_enable, pll_enable;
  logic [255:0] status_bits;
  logic [3:0]   gpio_in, gpio_out, gpio_oe, gpio_sense;
  logic [1:0]   crystal_pin_mode, e;
  logic [2:0]   input_enable, output_enable;
  logic [3:0]   cfg [4];
  logic [7:0]   pick [4];
  int           fails, num_checks, p;

  global_config_and_gpio_regs #(.NUM_PINS(4), .STATUS_IMPL(TB_IMPL)) dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .status_bits(status_bits), .external_switch_option(external_switch_option),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_sense(gpio_sense),
    .doubler_enable(doubler_enable), .crystal_pin_mode(crystal_pin_mode),
    .crystal_driver_on(crystal_driver_on), .osc_pin_a_single_ended(osc_pin_a_single_ended),
    .external_switch(external_switch), .synth_block_enable(synth_block_enable),
    .pll_enable(pll_enable), .input_enable(input_enable), .output_enable(output_enable));

  always #5 core_clk = ~core_clk;

  // ---------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check("reg_rvalid", reg_rvalid, 1);
    check("reg_rdata", reg_rdata, exp);
  endtask

  // Returns {oe, out}; a pick that names no usable bit drives low in status modes
  function automatic logic [1:0] pin_exp(input logic [3:0] cd, input logic [7:0] pk,
                                         input logic [255:0] sb);
    logic s;
    s = sb[pk];
    if (cd[3:2] == 2'b01 && (!TB_IMPL[pk] || pk[7:3] == 5'd2))
      return 2'b10;
    case (cd)
      4'h2: return 2'b10;
      4'h3: return 2'b11;
      4'h4: return {1'b1, s};
      4'h5: return {1'b1, ~s};
      4'h6: return {~s, 1'b0};
      4'h7: return {s, 1'b0};
      default: return 2'b00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {rst_b, reg_wr, reg_rd, external_switch_option, reg_addr, reg_wdata} = '0;
    {status_bits, gpio_in} = '0;
    for (int q = 0; q < 4; q++)
      {cfg[q], pick[q]} = '0;
    void'($urandom(32'hfa65_7db5));
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 12; i++)
      rd(ADDRS[i], 8'h00);
    check("enables", {pll_enable, synth_block_enable, input_enable, output_enable}, 0);
    repeat (4)
      for (int i = 0; i < 12; i++)
      begin
        b = 8'($urandom);
        wr(ADDRS[i], b);
        rd(ADDRS[i], b & MASKS[i]);
      end
    // Crystal driver on and settled before the doubler is used; the wait is shortened
    wr(MASTER_CONFIG_FIRST_ADDR, {6'h00, XTAL_DRIVER});
    repeat (100) @(negedge core_clk);
    for (int i = 0; i < 16; i++)
    begin
      b = 8'($urandom);
      c = 8'($urandom);
      o = 8'($urandom);
      wr(MASTER_CONFIG_FIRST_ADDR, {5'($urandom), i[2:0]});
      wr(PLL_BLOCK_ENABLE_ADDR, b);
      wr(INPUT_PATH_ENABLE_ADDR, c);
      wr(OUTPUT_PATH_ENABLE_ADDR, o);
      @(negedge core_clk);
      check("doubler_enable", doubler_enable, i[2]);
      check("crystal_pin_mode", crystal_pin_mode, i[1:0]);
      check("crystal_driver_on", crystal_driver_on, i[1:0] == 2'b01);
      check("osc_pin_a_single_ended", osc_pin_a_single_ended, i[1:0] == 2'b10);
      check("pll_enable", pll_enable, b[0]);
      check("synth_block_enable", synth_block_enable, b[4]);
      check("input_enable", input_enable, c[2:0]);
      check("output_enable", output_enable, o[2:0]);
    end
    // Pins 2 and 3 still hold codes left by the readback test
    wr(PIN_CONFIG_HIGH_PAIR_ADDR, 8'h00);
    // Every pin code once, then forced bad picks, then random ones
    for (int i = 0; i < 48; i++)
    begin
      p = i % 4;
      cfg[p] = (i < 16) ? i[3:0] : 4'($urandom);
      pick[p] = 8'($urandom);
      if (i >= 16 && i < 20)
      begin
        cfg[p] = 4'h4 + 4'(i[1:0]);
        pick[p] = i[0] ? 8'h1d : 8'h13;
      end
      for (int j = 0; j < 8; j++)
        status_bits[j*32 +: 32] = $urandom;
      gpio_in = 4'($urandom);
      wr(PIN0_STATUS_PICK_ADDR + 12'(p), pick[p]);
      if (p < 2)
        wr(PIN_CONFIG_LOW_PAIR_ADDR, {cfg[1], cfg[0]});
      else
        wr(PIN_CONFIG_HIGH_PAIR_ADDR, {cfg[3], cfg[2]});
      @(negedge core_clk);
      for (int q = 0; q < 4; q++)
      begin
        e = pin_exp(cfg[q], pick[q], status_bits);
        check("gpio_oe", gpio_oe[q], e[1]);
        if (e[1])
          check("gpio_out", gpio_out[q], e[0]);
        check("gpio_sense", gpio_sense[q], gpio_in[q] ^ (cfg[q] == PIN_IN_INV));
      end
      wr(PIN_LEVEL_STATUS_ADDR, 8'hff);
      rd(PIN_LEVEL_STATUS_ADDR, {4'h0, gpio_in});
    end
    // Odd pins inverted inputs, even pins plain inputs
    wr(PIN_CONFIG_LOW_PAIR_ADDR, 8'h10);
    wr(PIN_CONFIG_HIGH_PAIR_ADDR, 8'h10);
    for (int s = 0; s < 8; s++)
    begin
      external_switch_option = s[2];
      gpio_in = 4'($urandom);
      wr(SWITCH_SOURCE_SELECT_ADDR, {1'b0, s[1:0], 5'h00});
      @(negedge core_clk);
      check("external_switch", external_switch, s[2] & (gpio_in[s[1:0]] ^ s[0]));
    end
    complete_run();
  end

  initial
  begin
    #100000;
    fails++;
    complete_run();
  end
endmodule
